//--- src/rxpm_pkg.sv
package rxpm_pkg;

	// register bus carrier
	typedef logic [15:0] rxpm_addr_t;
	typedef logic [15:0] rxpm_data_t;

	typedef struct packed {
		logic       wrStb;
		logic       rdStb;
		rxpm_addr_t addr;
		rxpm_data_t wrData;
	} rxpm_bus_t;

	// received byte stream, first byte after the delimiter follows start
	typedef struct packed {
		logic       start;
		logic       valid;
		logic [7:0] data;
		logic       frameEnd;
	} rxpm_rx_t;

	// sizes
	localparam int unsigned RXPM_PAT_BYTES  = 64;
	localparam int unsigned RXPM_PAT_WORDS  = 32;
	localparam int unsigned RXPM_MASK_WORDS = 4;
	localparam int unsigned RXPM_BYTE_W     = 8;

	// register map
	localparam rxpm_addr_t RXPM_PAT_BASE           = 16'h04A8;
	localparam rxpm_addr_t RXPM_PAT_BYTES_14_15    = 16'h04AF;
	localparam rxpm_addr_t RX_PATTERN_BYTES_46_47  = 16'h04BF;
	localparam rxpm_addr_t RX_PATTERN_BYTES_48_49  = 16'h04C0;
	localparam rxpm_addr_t RX_PATTERN_BYTES_50_51  = 16'h04C1;
	localparam rxpm_addr_t RX_PATTERN_BYTES_52_53  = 16'h04C2;
	localparam rxpm_addr_t RX_PATTERN_BYTES_54_55  = 16'h04C3;
	localparam rxpm_addr_t RX_PATTERN_BYTES_56_57  = 16'h04C4;
	localparam rxpm_addr_t RX_PATTERN_BYTES_58_59  = 16'h04C5;
	localparam rxpm_addr_t RX_PATTERN_BYTES_60_61  = 16'h04C6;
	localparam rxpm_addr_t RX_PATTERN_BYTES_62_63  = 16'h04C7;
	localparam rxpm_addr_t RX_PATTERN_MASK_0_15    = 16'h04C8;
	localparam rxpm_addr_t RX_PATTERN_MASK_16_31   = 16'h04C9;
	localparam rxpm_addr_t RX_PATTERN_MASK_32_47   = 16'h04CA;
	localparam rxpm_addr_t RX_PATTERN_MASK_48_63   = 16'h04CB;
	localparam rxpm_addr_t RX_PATTERN_MATCH_CONTROL = 16'h04CC;

	// fields and reset values
	localparam int unsigned RXPM_START_OFF_LSB = 0;
	localparam int unsigned RXPM_START_OFF_W   = 6;
	localparam logic [5:0]  RXPM_START_OFF_RST = 6'h0C;
	localparam logic [5:0]  RXPM_LAST_IDX      = 6'h3F;
	localparam rxpm_data_t  RXPM_PAT_RST       = 16'h0000;
	localparam rxpm_data_t  RXPM_MASK_RST      = 16'h0000;

	// matcher states, gray along idle -> skip -> compare
	typedef enum logic [1:0] {
		RXPM_IDLE = 2'b00,
		RXPM_SKIP = 2'b01,
		RXPM_CMP  = 2'b11
	} rxpm_fsm_t;

	typedef struct packed {
		logic [RXPM_PAT_WORDS-1:0][15:0]  patWord;
		logic [RXPM_MASK_WORDS-1:0][15:0] maskWord;
		logic [5:0]                       startOff;
		rxpm_fsm_t                        fsm;
		logic [5:0]                       cnt;
		logic                             miss;
		rxpm_data_t                       rdData;
		logic                             hit;
		logic                             missOut;
	} rxpm_state_t;

	localparam rxpm_state_t RXPM_STATE_RST = '{
		patWord:  {RXPM_PAT_WORDS{RXPM_PAT_RST}},
		maskWord: {RXPM_MASK_WORDS{RXPM_MASK_RST}},
		startOff: RXPM_START_OFF_RST,
		fsm:      RXPM_IDLE,
		cnt:      6'h00,
		miss:     1'b0,
		rdData:   16'h0000,
		hit:      1'b0,
		missOut:  1'b0
	};

endpackage

//--- src/rxpm_byte_cmp.sv
`timescale 1ns/1ns
`default_nettype none

module rxpm_byte_cmp #(
	parameter int unsigned W = 8
) (
	// operands
	input  wire logic [W-1:0] patByte,
	input  wire logic [W-1:0] rxByte,
	input  wire logic         maskBit,
	// result
	output logic              byteMiss
);
	// a masked byte never counts against the frame
	assign byteMiss = !maskBit && (patByte != rxByte);
endmodule // rxpm_byte_cmp

`default_nettype wire

//--- src/rxpm_match_cfg.sv
// How it works
// - each pattern register: odd byte in 15:8, even byte in 7:0, RW
// - pattern is 64 bytes, last register carries bytes 62 and 63
// - mask bit one excludes that byte from comparison, zero includes it
// - four 16-bit masks cover bytes 0-15, 16-31, 32-47, 48-63
// - control bits 5:0 give bytes after delimiter where comparing starts
// - offset is zero-based: zero compares from the first byte
// - offset resets to twelve, skipping both six-byte addresses
// - lower bytes sit in preceding registers, same two-byte layout
`timescale 1ns/1ns
`default_nettype none

module rxpm_match_cfg
	import rxpm_pkg::*;
#(
	parameter int unsigned PAT_BYTES = 64
) (
	// clock and reset
	input  wire logic                core_clk,
	input  wire logic                arst_n,
	// register port
	input  wire rxpm_pkg::rxpm_bus_t bus,
	output rxpm_pkg::rxpm_data_t     rdData,
	// received bytes
	input  wire rxpm_pkg::rxpm_rx_t  rx,
	// match result pulses
	output logic                     matchHit,
	output logic                     matchMiss
);
	import rxpm_pkg::*;

	if (PAT_BYTES != RXPM_PAT_BYTES) begin : g_badSize
		$error("pattern size must be 64 bytes");
	end

	rxpm_state_t st_r;
	rxpm_state_t st_nxt;

	rxpm_addr_t  patOff;
	rxpm_addr_t  maskOff;
	logic        patSel;
	logic        maskSel;
	logic        ctrlSel;
	logic [4:0]  patIdx;
	logic [1:0]  maskIdx;
	logic [5:0]  curIdx;
	logic [7:0]  patByte;
	logic        maskBit;
	logic        byteMiss;

	// decode; registers sit at their printed word offsets
	assign patOff  = bus.addr - RXPM_PAT_BASE;
	assign maskOff = bus.addr - RX_PATTERN_MASK_0_15;
	assign patSel  = (bus.addr >= RXPM_PAT_BASE) &&
		(bus.addr <= RX_PATTERN_BYTES_62_63);
	assign maskSel = (bus.addr >= RX_PATTERN_MASK_0_15) &&
		(bus.addr <= RX_PATTERN_MASK_48_63);
	assign ctrlSel = (bus.addr == RX_PATTERN_MATCH_CONTROL);
	assign patIdx  = patOff[4:0];
	assign maskIdx = maskOff[1:0];

	// byte under comparison: pattern byte 0 while still skipping
	assign curIdx  = (st_r.fsm == RXPM_SKIP) ? 6'h00 : st_r.cnt;
	assign patByte = curIdx[0] ? st_r.patWord[curIdx[5:1]][15:8]
		: st_r.patWord[curIdx[5:1]][7:0];
	assign maskBit = st_r.maskWord[curIdx[5:4]][curIdx[3:0]];

	rxpm_byte_cmp #(
		.W(RXPM_BYTE_W)
	) u_cmp (
		.patByte  (patByte),
		.rxByte   (rx.data),
		.maskBit  (maskBit),
		.byteMiss (byteMiss)
	);

	always_comb begin
		st_nxt         = st_r;
		st_nxt.rdData  = 16'h0000;
		st_nxt.hit     = 1'b0;
		st_nxt.missOut = 1'b0;

		// software writes
		if (bus.wrStb) begin
			if (patSel) begin
				st_nxt.patWord[patIdx] = bus.wrData;
			end else if (maskSel) begin
				st_nxt.maskWord[maskIdx] = bus.wrData;
			end else if (ctrlSel) begin
				st_nxt.startOff = bus.wrData[5:0];
			end
		end

		// software reads; unmapped and reserved bits read zero
		if (bus.rdStb) begin
			if (patSel) begin
				st_nxt.rdData = st_r.patWord[patIdx];
			end else if (maskSel) begin
				st_nxt.rdData = st_r.maskWord[maskIdx];
			end else if (ctrlSel) begin
				st_nxt.rdData = {10'h000, st_r.startOff};
			end
		end

		// matcher runs on the stored config of the previous cycle
		unique case (st_r.fsm)
			RXPM_IDLE: begin
			end
			RXPM_SKIP: begin
				if (rx.valid) begin
					if (st_r.cnt == st_r.startOff) begin
						st_nxt.miss = byteMiss;
						st_nxt.cnt  = 6'h01;
						st_nxt.fsm  = RXPM_CMP;
					end else begin
						st_nxt.cnt = st_r.cnt + 6'h01;
					end
				end
			end
			RXPM_CMP: begin
				if (rx.valid) begin
					if (st_r.cnt == RXPM_LAST_IDX) begin
						st_nxt.hit     = !(st_r.miss || byteMiss);
						st_nxt.missOut = st_r.miss || byteMiss;
						st_nxt.fsm     = RXPM_IDLE;
					end else begin
						st_nxt.miss = st_r.miss || byteMiss;
						st_nxt.cnt  = st_r.cnt + 6'h01;
					end
				end
			end
			default: begin
				st_nxt.fsm = RXPM_IDLE;
			end
		endcase

		// a frame too short to cover the whole pattern never matches
		if (rx.frameEnd && st_nxt.fsm != RXPM_IDLE) begin
			st_nxt.missOut = 1'b1;
			st_nxt.fsm     = RXPM_IDLE;
		end

		// a new delimiter restarts counting, dropping any frame in progress
		if (rx.start) begin
			st_nxt.fsm     = RXPM_SKIP;
			st_nxt.cnt     = 6'h00;
			st_nxt.miss    = 1'b0;
			st_nxt.hit     = 1'b0;
			st_nxt.missOut = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= RXPM_STATE_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rdData    = st_r.rdData;
	assign matchHit  = st_r.hit;
	assign matchMiss = st_r.missOut;

	// assertion helper: has software ever written the control register
	logic ctrlTouched_r;
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrlTouched_r <= 1'b0;
		end else if (bus.wrStb && ctrlSel) begin
			ctrlTouched_r <= 1'b1;
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);

	sequence s_wrThenRd(rxpm_addr_t a);
		(bus.wrStb && bus.addr == a) ##1 (bus.rdStb && bus.addr == a);
	endsequence

	property p_patLayout;
		s_wrThenRd(RX_PATTERN_BYTES_46_47)
		|=> rdData[15:8] == $past(bus.wrData[15:8], 2)
			&& rdData[7:0] == $past(bus.wrData[7:0], 2);
	endproperty
	a_patLayout: assert property (p_patLayout)
		else $error("pattern register read back wrong");

	property p_lastPatWord;
		bus.wrStb && bus.addr == RX_PATTERN_BYTES_62_63
		|=> st_r.patWord[31] == $past(bus.wrData);
	endproperty
	a_lastPatWord: assert property (p_lastPatWord)
		else $error("bytes 62 and 63 not held by last register");

	property p_maskedByte;
		st_r.fsm == RXPM_CMP && rx.valid && maskBit
		&& !st_r.miss && st_r.cnt == RXPM_LAST_IDX && !rx.start
		|=> matchHit && !matchMiss;
	endproperty
	a_maskedByte: assert property (p_maskedByte)
		else $error("masked last byte blocked a match");

	property p_maskWord;
		bus.wrStb && bus.addr == RX_PATTERN_MASK_48_63
		|=> st_r.maskWord[3] == $past(bus.wrData);
	endproperty
	a_maskWord: assert property (p_maskWord)
		else $error("fourth mask register not written");

	property p_ctrlRead;
		bus.rdStb && ctrlSel
		|=> rdData == {10'h000, $past(st_r.startOff)} ##1 rdData == 16'h0000
			|| $past(bus.rdStb);
	endproperty
	a_ctrlRead: assert property (p_ctrlRead)
		else $error("control read shows wrong offset");

	sequence s_skipDone;
		st_r.fsm == RXPM_SKIP && rx.valid && st_r.cnt == st_r.startOff
		&& !rx.start && !rx.frameEnd;
	endsequence

	property p_zeroBased;
		s_skipDone |=> st_r.fsm == RXPM_CMP && st_r.cnt == 6'h01;
	endproperty
	a_zeroBased: assert property (p_zeroBased)
		else $error("compare did not start at the offset byte");

	property p_resetOffset;
		!ctrlTouched_r |-> st_r.startOff == RXPM_START_OFF_RST;
	endproperty
	a_resetOffset: assert property (p_resetOffset)
		else $error("start offset not twelve after reset");

	property p_lowerLayout;
		rxpm_data_t d;
		(bus.wrStb && bus.addr == RXPM_PAT_BYTES_14_15, d = bus.wrData)
		|=> st_r.patWord[7] == d;
	endproperty
	a_lowerLayout: assert property (p_lowerLayout)
		else $error("bytes 14 and 15 not in their register");

	property p_fullMatch;
		st_r.fsm == RXPM_CMP && rx.valid && st_r.cnt == RXPM_LAST_IDX
		&& !st_r.miss && !byteMiss && !rx.start
		|=> matchHit ##1 !matchHit;
	endproperty
	a_fullMatch: assert property (p_fullMatch)
		else $error("all bytes equal but no match pulse");

	property p_missSticky;
		st_r.fsm == RXPM_CMP && rx.valid && byteMiss && !rx.start
		|=> !matchHit && (st_r.miss || matchMiss);
	endproperty
	a_missSticky: assert property (p_missSticky)
		else $error("mismatch still produced a match");

	property p_patWrite;
		bus.wrStb && patSel
		|=> st_r.patWord[$past(patIdx)] == $past(bus.wrData);
	endproperty
	a_patWrite: assert property (p_patWrite)
		else $error("pattern register write lost");

	property p_maskWrite;
		bus.wrStb && maskSel
		|=> st_r.maskWord[$past(maskIdx)] == $past(bus.wrData);
	endproperty
	a_maskWrite: assert property (p_maskWrite)
		else $error("mask register write lost");

	property p_ctrlWrite;
		bus.wrStb && ctrlSel
		|=> st_r.startOff == $past(bus.wrData[5:0]);
	endproperty
	a_ctrlWrite: assert property (p_ctrlWrite)
		else $error("start offset not taken from bits 5:0");

	property p_startRestart;
		rx.start
		|=> st_r.fsm == RXPM_SKIP && st_r.cnt == 6'h00 && !matchHit && !matchMiss;
	endproperty
	a_startRestart: assert property (p_startRestart)
		else $error("delimiter did not restart byte counting");

	// a frame cut before pattern byte 63 must still report
	sequence s_cutFrame;
		st_r.fsm == RXPM_CMP && rx.frameEnd && !rx.start
		&& !(rx.valid && st_r.cnt == RXPM_LAST_IDX);
	endsequence

	property p_shortFrame;
		s_cutFrame |=> matchMiss && !matchHit;
	endproperty
	a_shortFrame: assert property (p_shortFrame)
		else $error("cut frame gave no miss pulse");

	property p_oneResult;
		matchHit |-> !matchMiss;
	endproperty
	a_oneResult: assert property (p_oneResult)
		else $error("hit and miss pulses at once");

endmodule // rxpm_match_cfg

`default_nettype wire

//--- testbench/rxpm_match_cfg_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin \
	bad_count++; $display("ERROR %s expected %h seen %h", nm, exp, got); \
	end end

module rxpm_match_cfg_tb_top;
	import rxpm_pkg::*;

	logic       core_clk;
	logic       arst_n;
	rxpm_bus_t  bus;
	rxpm_data_t rdData;
	rxpm_rx_t   rx;
	logic       matchHit;
	logic       matchMiss;
	int         bad_count;
	int         n_tests;

	rxpm_match_cfg #(.PAT_BYTES(64)) DUT (
		.core_clk  (core_clk),
		.arst_n    (arst_n),
		.bus       (bus),
		.rdData    (rdData),
		.rx        (rx),
		.matchHit  (matchHit),
		.matchMiss (matchMiss)
	);

	// odd multiplier keeps all 64 pattern bytes distinct
	function automatic logic [7:0] patByte(input int j);
		return 8'(j * 29 + 5);
	endfunction

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// each strobe is followed by an idle edge so no signal is set twice
	task automatic wr(input rxpm_addr_t a, input rxpm_data_t d);
		@(posedge core_clk);
		bus <= '{wrStb: 1'b1, rdStb: 1'b0, addr: a, wrData: d};
		@(posedge core_clk);
		bus <= '0;
	endtask

	task automatic rdChk(input rxpm_addr_t a, input rxpm_data_t exp);
		@(posedge core_clk);
		bus <= '{wrStb: 1'b0, rdStb: 1'b1, addr: a, wrData: 16'h0000};
		@(posedge core_clk);
		bus <= '0;
		#1;
		`CHK("rdData", exp, rdData)
		@(posedge core_clk);
		#1;
		`CHK("rdData idle", 16'h0000, rdData)
	endtask

	// write then read with no gap between the strobes
	task automatic wrRdChk(input rxpm_addr_t a, input rxpm_data_t d);
		@(posedge core_clk);
		bus <= '{wrStb: 1'b1, rdStb: 1'b0, addr: a, wrData: d};
		@(posedge core_clk);
		bus <= '{wrStb: 1'b0, rdStb: 1'b1, addr: a, wrData: 16'h0000};
		@(posedge core_clk);
		bus <= '0;
		#1;
		`CHK("rdData after write", d, rdData)
	endtask

	task automatic rxDrv(input logic s, input logic v, input logic [7:0] d,
		input logic e);
		@(posedge core_clk);
		rx <= '{start: s, valid: v, data: d, frameEnd: e};
	endtask

	// off filler bytes, then the pattern; byte bad is corrupted
	task automatic frame(input int off, input int bad, input logic expHit);
		rxDrv(1'b1, 1'b0, 8'h00, 1'b0);
		for (int n = 0; n < off + 64; n++) begin
			logic e;
			e = (n == off + 63);
			if (n < off) rxDrv(1'b0, 1'b1, 8'hA5, e);
			else if (n - off == bad) rxDrv(1'b0, 1'b1, ~patByte(n - off), e);
			else rxDrv(1'b0, 1'b1, patByte(n - off), e);
		end
		rxDrv(1'b0, 1'b0, 8'h00, 1'b0);
		#1;
		`CHK("matchHit", expHit, matchHit)
		`CHK("matchMiss", ~expHit, matchMiss)
		@(posedge core_clk);
		#1;
		`CHK("result pulse", 2'b00, {matchHit, matchMiss})
	endtask

	task automatic t_reset;
		rdChk(RX_PATTERN_MATCH_CONTROL, 16'h000C);
		for (int k = 0; k < 4; k++)
			rdChk(RX_PATTERN_MASK_0_15 + 16'(k), 16'h0000);
		rdChk(RX_PATTERN_BYTES_62_63, 16'h0000);
		$display("test reset done");
	endtask

	task automatic t_regs;
		for (int k = 0; k < 32; k++) begin
			wr(RXPM_PAT_BASE + 16'(k), {patByte(2 * k + 1), patByte(2 * k)});
		end
		for (int k = 0; k < 32; k++) begin
			rdChk(RXPM_PAT_BASE + 16'(k), {patByte(2 * k + 1), patByte(2 * k)});
		end
		rdChk(RX_PATTERN_BYTES_62_63, {patByte(63), patByte(62)});
		rdChk(RX_PATTERN_BYTES_46_47, {patByte(47), patByte(46)});
		wrRdChk(RX_PATTERN_BYTES_46_47, 16'h5AC3);
		wrRdChk(RX_PATTERN_BYTES_46_47, {patByte(47), patByte(46)});
		wr(RX_PATTERN_MATCH_CONTROL, 16'hFFFF);
		rdChk(RX_PATTERN_MATCH_CONTROL, 16'h003F);
		for (int k = 0; k < 4; k++)
			wr(RX_PATTERN_MASK_0_15 + 16'(k), 16'h1234 * 16'(k + 1));
		for (int k = 0; k < 4; k++)
			rdChk(RX_PATTERN_MASK_0_15 + 16'(k),
				16'h1234 * 16'(k + 1));
		wr(16'h04CD, 16'hBEEF);
		rdChk(16'h04CD, 16'h0000);
		$display("test registers done");
	endtask

	task automatic t_mask;
		wr(RX_PATTERN_MATCH_CONTROL, 16'h0000);
		for (int k = 0; k < 4; k++) wr(RX_PATTERN_MASK_0_15 + 16'(k), 16'h0000);
		frame(0, -1, 1'b1);
		frame(0, 63, 1'b0);
		for (int k = 0; k < 4; k++) begin
			wr(RX_PATTERN_MASK_0_15 + 16'(k), 16'h0002 << k);
			frame(0, 16 * k + k + 1, 1'b1);
			frame(0, 16 * k + k, 1'b0);
			wr(RX_PATTERN_MASK_0_15 + 16'(k), 16'h0000);
		end
		wr(RX_PATTERN_MASK_48_63, 16'h8000);
		frame(0, 63, 1'b1);
		wr(RX_PATTERN_MASK_48_63, 16'h0000);
		$display("test mask done");
	endtask

	task automatic t_offset;
		wr(RX_PATTERN_MATCH_CONTROL, 16'h0001);
		frame(1, -1, 1'b1);
		wr(RX_PATTERN_MATCH_CONTROL, 16'h000C);
		frame(12, -1, 1'b1);
		frame(11, -1, 1'b0);
		$display("test offset done");
	endtask

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	initial begin
		#2000000;
		bad_count++;
		tally_and_finish;
	end

	initial begin
		arst_n = 1'b0;
		bus = '0;
		rx = '0;
		bad_count = 0;
		n_tests = 0;
		repeat (2) @(posedge core_clk);
		arst_n <= 1'b1;
		t_reset;
		t_regs;
		t_mask;
		t_offset;
		tally_and_finish;
	end

endmodule // rxpm_match_cfg_tb_top

`default_nettype wire
